// ==== src/timer_regs.vh ====
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
// Registers sit one to a word, so each byte address is four times the index.
`define IDX_TIMER_CONTROL 10'h088
`define IDX_COUNT_LOW 10'h08A
`define IDX_RELOAD_LOW 10'h08B
`define IDX_COUNT_HIGH 10'h08C
`define IDX_RELOAD_HIGH 10'h08D
`define IDX_INTERRUPT_ENABLE 10'h0A8
`define ADDR_TIMER_CONTROL 10'h220
`define ADDR_COUNT_LOW 10'h228
`define ADDR_RELOAD_LOW 10'h22C
`define ADDR_COUNT_HIGH 10'h230
`define ADDR_RELOAD_HIGH 10'h234
`define ADDR_INTERRUPT_ENABLE 10'h2A0

// ----------------------------------------
// Field positions
// ----------------------------------------
// Timer control register.
`define TC_GATE 7
`define TC_COUNT_SOURCE 6
`define TC_OVERFLOW_FLAG 5
`define TC_RUN_ENABLE 4
`define TC_REQ_A_EDGE_FLAG 3
`define TC_REQ_A_EDGE_MODE 2
// Interrupt enable register.
`define IE_GLOBAL 7
`define IE_OVERFLOW 1
`define IE_REQ_A 0

// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define RST_TIMER_CONTROL 8'h00
`define RST_COUNT 8'h00
`define RST_RELOAD 8'h00
`define RST_INTERRUPT_ENABLE 8'h00
// Oscillator clocks per machine cycle, and the last prescaler value.
`define OSC_PER_MACHINE_CYCLE 12
`define PRESCALE_LAST 4'hB

`endif

// ==== src/auto_reload_timer_counter.v ====
// What this block does
// - Timer mode advances once per twelve clocks.
// - Source select one counts pin, zero internal.
// - Count only while run enable is set.
// - High and low bytes form one counter.
// - Overflow reloads count; reload registers unchanged.
// - Overflow sets flag; enabled flag raises interrupt.
// - Flag clears on vector and reset.
// - Gate one: count only while pin high.
// - Gate zero: pin level is ignored.
// - Edge on request pin sets edge flag.
// - One fixed auto-reload mode, no mode register.
// - Count input and request pins are port alternates.
//
// Chosen here: the Avalon-MM slave port.
`include "timer_regs.vh"

module auto_reload_timer_counter (
  // Clock and reset.
  input wire ref_clk_i,
  input wire rst_n_i,
  // Avalon-MM register slave.
  input wire [9:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // Pins, taken from the port alternate functions.
  input wire count_input_pin_i,
  input wire external_request_a_pin_n_i,
  // Interrupt request and vector acknowledge.
  input wire overflow_vector_ack_i,
  input wire request_a_vector_ack_i,
  output wire overflow_irq_o,
  output wire request_a_irq_o
);

  // ----------------------------------------
  // Registers and wires
  // ----------------------------------------
  reg gate_r;
  reg count_source_r;
  reg overflow_flag_r;
  reg run_enable_r;
  reg request_a_edge_flag_r;
  reg request_a_edge_mode_r;
  reg global_irq_enable_r;
  reg overflow_irq_enable_r;
  reg request_a_irq_enable_r;
  reg [7:0] count_low_r;
  reg [7:0] count_high_r;
  reg [7:0] reload_low_r;
  reg [7:0] reload_high_r;
  reg [3:0] prescale_r;
  reg count_pin_sample_r;
  reg req_a_prev_r;
  reg ack_r;
  reg [7:0] rd_byte;
  wire request;
  wire wr_en;
  wire machine_tick;
  wire count_pin_fall;
  wire req_a_level;
  wire req_a_fall;
  wire gate_open;
  wire source_tick;
  wire increment;
  wire [15:0] count_now;
  wire overflow;
  wire wr_ctrl;
  wire wr_cnt_lo;
  wire wr_cnt_hi;
  wire [7:0] wdata;
  wire [15:0] count_inc;
  wire [1:0] pin_raw;
  wire [1:0] pin_sync;
  genvar g;

  // Reset images of the control and interrupt enable registers, bit by bit.
  localparam [7:0] ctl_rst = `RST_TIMER_CONTROL;
  localparam [7:0] ie_rst = `RST_INTERRUPT_ENABLE;

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // Each access takes one wait state; the second cycle completes it.
  // The wait state lets read data come from a flop rather than the mux.
  assign request = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = request & ~ack_r;
  assign wr_en = avs_write_i & ack_r & avs_byteenable_i[0];
  assign wdata = avs_writedata_i[7:0];

  // Acknowledge toggles high for the completing cycle of each access.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= request & ~ack_r;
    end
  end

  // Read mux; unmapped addresses read as zero.
  always @* begin
    rd_byte = 8'h00;
    case (avs_address_i)
      `ADDR_TIMER_CONTROL: begin
        rd_byte = {gate_r, count_source_r, overflow_flag_r, run_enable_r,
                   request_a_edge_flag_r, request_a_edge_mode_r, 2'h0};
      end
      `ADDR_COUNT_LOW: begin
        rd_byte = count_low_r;
      end
      `ADDR_RELOAD_LOW: begin
        rd_byte = reload_low_r;
      end
      `ADDR_COUNT_HIGH: begin
        rd_byte = count_high_r;
      end
      `ADDR_RELOAD_HIGH: begin
        rd_byte = reload_high_r;
      end
      `ADDR_INTERRUPT_ENABLE: begin
        rd_byte = {global_irq_enable_r, 5'h00, overflow_irq_enable_r,
                   request_a_irq_enable_r};
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Read data is captured in the wait cycle and stands when it ends.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack_r) begin
      avs_readdata_o <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  // pin alternates
  // Both pins pass two flip-flops before any logic looks at them. The stages
  // reset high, the idle level of both pins, so no false edge follows reset.
  assign pin_raw = {external_request_a_pin_n_i, count_input_pin_i};

  // One two-stage synchroniser per pin; bit 0 is the count pin.
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pin_sync
      reg [1:0] stage_r;
      always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          stage_r <= 2'h3;
        end else begin
          stage_r <= {stage_r[0], pin_raw[g]};
        end
      end
      assign pin_sync[g] = stage_r[1];
    end
  endgenerate

  // The previous synchronised request level feeds the edge detector.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_a_prev_r <= 1'b1;
    end else begin
      req_a_prev_r <= pin_sync[1];
    end
  end

  assign req_a_level = pin_sync[1];
  assign req_a_fall = req_a_prev_r & ~pin_sync[1];

  // ----------------------------------------
  // Machine cycle prescaler
  // ----------------------------------------
  // divide by twelve
  // The prescaler free-runs so that one tick marks every machine cycle.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescale_r <= 4'h0;
    end else if (prescale_r == `PRESCALE_LAST) begin
      prescale_r <= 4'h0;
    end else begin
      prescale_r <= prescale_r + 4'h1;
    end
  end

  assign machine_tick = (prescale_r == `PRESCALE_LAST);

  // sampled falling edge
  // The count pin is sampled once per machine cycle; a one-to-zero change
  // between two samples is one count.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_pin_sample_r <= 1'b1;
    end else if (machine_tick) begin
      count_pin_sample_r <= pin_sync[0];
    end
  end

  assign count_pin_fall = machine_tick & count_pin_sample_r & ~pin_sync[0];

  // ----------------------------------------
  // Count enable and overflow
  // ----------------------------------------
  // gated by pin
  // gate ignored
  // The gate looks at the synchronised level, so it acts two clocks after
  // the pin moves; a gate pulse shorter than that may be missed.
  assign gate_open = ~gate_r | req_a_level;
  assign source_tick = count_source_r ? count_pin_fall : machine_tick;
  assign increment = run_enable_r & gate_open & source_tick;
  assign count_now = {count_high_r, count_low_r};
  assign count_inc = count_now + 16'h0001;
  assign wr_ctrl = wr_en & (avs_address_i == `ADDR_TIMER_CONTROL);
  assign wr_cnt_lo = wr_en & (avs_address_i == `ADDR_COUNT_LOW);
  assign wr_cnt_hi = wr_en & (avs_address_i == `ADDR_COUNT_HIGH);
  // A count write in the same cycle cancels that cycle's increment.
  assign overflow = increment & (count_now == 16'hFFFF) & ~wr_cnt_lo & ~wr_cnt_hi;

  // ----------------------------------------
  // Count and reload registers
  // ----------------------------------------
  // single auto-reload mode
  // There is no mode register; the counter always runs 16-bit with reload.
  // A software count write outranks both reload and increment in its cycle.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_low_r <= `RST_COUNT;
      count_high_r <= `RST_COUNT;
    end else if (wr_cnt_lo || wr_cnt_hi) begin
      if (wr_cnt_lo) begin
        count_low_r <= wdata;
      end
      if (wr_cnt_hi) begin
        count_high_r <= wdata;
      end
    end else if (overflow) begin
      count_low_r <= reload_low_r;
      count_high_r <= reload_high_r;
    end else if (increment) begin
      count_low_r <= count_inc[7:0];
      count_high_r <= count_inc[15:8];
    end
  end

  // Reload registers change only through software writes.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reload_low_r <= `RST_RELOAD;
      reload_high_r <= `RST_RELOAD;
    end else begin
      if (wr_en && avs_address_i == `ADDR_RELOAD_LOW) begin
        reload_low_r <= wdata;
      end
      if (wr_en && avs_address_i == `ADDR_RELOAD_HIGH) begin
        reload_high_r <= wdata;
      end
    end
  end

  // ----------------------------------------
  // Control and interrupt enable registers
  // ----------------------------------------
  // Plain control bits follow software writes.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_r <= ctl_rst[`TC_GATE];
      count_source_r <= ctl_rst[`TC_COUNT_SOURCE];
      run_enable_r <= ctl_rst[`TC_RUN_ENABLE];
      request_a_edge_mode_r <= ctl_rst[`TC_REQ_A_EDGE_MODE];
    end else if (wr_ctrl) begin
      gate_r <= wdata[`TC_GATE];
      count_source_r <= wdata[`TC_COUNT_SOURCE];
      run_enable_r <= wdata[`TC_RUN_ENABLE];
      request_a_edge_mode_r <= wdata[`TC_REQ_A_EDGE_MODE];
    end
  end

  // cleared on vector
  // A hardware set wins over a software clear or a vector acknowledge.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overflow_flag_r <= ctl_rst[`TC_OVERFLOW_FLAG];
    end else if (overflow) begin
      overflow_flag_r <= 1'b1;
    end else if (wr_ctrl) begin
      overflow_flag_r <= wdata[`TC_OVERFLOW_FLAG];
    end else if (overflow_vector_ack_i) begin
      overflow_flag_r <= 1'b0;
    end
  end

  // edge flag
  // In edge mode a falling pin edge sets the flag; in level mode the flag
  // follows the active low pin.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      request_a_edge_flag_r <= ctl_rst[`TC_REQ_A_EDGE_FLAG];
    end else if (!request_a_edge_mode_r) begin
      request_a_edge_flag_r <= ~req_a_level;
    end else if (req_a_fall) begin
      request_a_edge_flag_r <= 1'b1;
    end else if (wr_ctrl) begin
      request_a_edge_flag_r <= wdata[`TC_REQ_A_EDGE_FLAG];
    end else if (request_a_vector_ack_i) begin
      request_a_edge_flag_r <= 1'b0;
    end
  end

  // Interrupt enable bits.
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      global_irq_enable_r <= ie_rst[`IE_GLOBAL];
      overflow_irq_enable_r <= ie_rst[`IE_OVERFLOW];
      request_a_irq_enable_r <= ie_rst[`IE_REQ_A];
    end else if (wr_en && avs_address_i == `ADDR_INTERRUPT_ENABLE) begin
      global_irq_enable_r <= wdata[`IE_GLOBAL];
      overflow_irq_enable_r <= wdata[`IE_OVERFLOW];
      request_a_irq_enable_r <= wdata[`IE_REQ_A];
    end
  end

  // ----------------------------------------
  // Interrupt requests
  // ----------------------------------------
  // interrupt request
  // Both requests are levels; they stay up until the flag or an enable drops.
  assign overflow_irq_o = global_irq_enable_r & overflow_irq_enable_r & overflow_flag_r;
  assign request_a_irq_o = global_irq_enable_r & request_a_irq_enable_r &
                           request_a_edge_flag_r;

endmodule // auto_reload_timer_counter

// ==== testbench/timer_sva.sv ====
`include "timer_regs.vh"
// ----------------------------------------
// Bus and interrupt checks
// ----------------------------------------
module timer_sva (
  // Watched ports.
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [9:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire overflow_vector_ack_i,
  input wire overflow_irq_o,
  input wire request_a_irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // A pending request, and whether it hits a register.
  wire req = avs_read_i | avs_write_i;
  wire hit = avs_address_i inside {`ADDR_TIMER_CONTROL, `ADDR_COUNT_LOW, `ADDR_RELOAD_LOW,
    `ADDR_COUNT_HIGH, `ADDR_RELOAD_HIGH, `ADDR_INTERRUPT_ENABLE};
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest_o)
    else $error("first request cycle not stalled");
  a_wait_once: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("more than one wait state");
  a_wait_idle: assert property (!req |-> !avs_waitrequest_o)
    else $error("stall without request");
  a_data_lane: assert property (avs_readdata_o[31:8] == 24'h0)
    else $error("upper read lanes not zero");
  a_data_stands: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data moved without read");
  a_unmapped_zero: assert property (avs_read_i && avs_waitrequest_o && !hit
    |=> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_ack_clears: assert property (overflow_vector_ack_i |=> !overflow_irq_o)
    else $error("vector ack left overflow request");
  a_irq_reset: assert property ($rose(rst_n_i) |-> !overflow_irq_o && !request_a_irq_o)
    else $error("request high after reset");
endmodule // timer_sva

bind auto_reload_timer_counter timer_sva i_sva (.ref_clk_i, .rst_n_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .overflow_vector_ack_i,
  .overflow_irq_o, .request_a_irq_o);

// ==== testbench/pin_model.sv ====
// ----------------------------------------
// Count pulse source and request pin
// ----------------------------------------
module pin_model (
  // Clock and bench commands.
  input wire ref_clk_i,
  input wire start_i,
  input wire [3:0] pulses_i,
  input wire level_i,
  // Pins and status.
  output logic count_pin_o,
  output wire request_pin_n_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign request_pin_n_o = level_i;
  initial begin
    count_pin_o = 1'b1;
    done_o = 1'b0;
    forever begin
      @(posedge ref_clk_i);
      if (start_i === 1'b1) begin
        done_o <= 1'b0;
        repeat (pulses_i) begin
          count_pin_o <= 1'b0;
          repeat (16) @(posedge ref_clk_i);
          count_pin_o <= 1'b1;
          repeat (16) @(posedge ref_clk_i);
        end
        done_o <= 1'b1;
      end
    end
  end
endmodule // pin_model

// ==== testbench/test_auto_reload_timer_counter.sv ====
`include "timer_regs.vh"
// ----------------------------------------
// Timer bench
// ----------------------------------------
module test_auto_reload_timer_counter;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] ctl = `ADDR_TIMER_CONTROL;
  logic ref_clk_i, rst_n_i, avs_read_i, avs_write_i, ov_ack, rq_ack, start, lvl;
  logic [9:0] avs_address_i;
  logic [31:0] avs_writedata_i, seed;
  logic [3:0] avs_byteenable_i, npulse;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o, cpin, rpin_n, done, overflow_irq_o, request_a_irq_o;
  logic [31:0] exp_q[$];
  logic [9:0] regs[6] = '{ctl, `ADDR_COUNT_LOW, `ADDR_RELOAD_LOW, `ADDR_COUNT_HIGH,
    `ADDR_RELOAD_HIGH, `ADDR_INTERRUPT_ENABLE};
  int bad_count, n_compared, i;
  auto_reload_timer_counter i_dut (.ref_clk_i, .rst_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .count_input_pin_i(cpin), .external_request_a_pin_n_i(rpin_n),
    .overflow_vector_ack_i(ov_ack), .request_a_vector_ack_i(rq_ack), .overflow_irq_o,
    .request_a_irq_o);
  pin_model i_pins (.ref_clk_i, .start_i(start), .pulses_i(npulse), .level_i(lvl),
    .count_pin_o(cpin), .request_pin_n_o(rpin_n), .done_o(done));
  // Free-running clock.
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task summarize;
    if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus cycle, held until waitrequest is seen low at a rising edge.
  task bus(input logic rd, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge ref_clk_i);
    avs_read_i <= rd;
    avs_write_i <= !rd;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) begin
      cmp(32'h0, 32'h1);
      summarize();
    end
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b0, a, {24'h0, d}, 4'h1);
  endtask
  task rd(input logic [9:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b1, a, 32'h0, 4'h1);
  endtask
  task wcnt(input logic [15:0] v);
    wr(`ADDR_COUNT_LOW, v[7:0]);
    wr(`ADDR_COUNT_HIGH, v[15:8]);
  endtask
  task rcnt(input logic [15:0] v);
    rd(`ADDR_COUNT_LOW, v[7:0]);
    rd(`ADDR_COUNT_HIGH, v[15:8]);
  endtask
  // Enables counting for exactly 12 * n clocks, optionally reading control near the end.
  task run(input logic [7:0] c, input logic [7:0] stp, input int n, input logic mid);
    wr(ctl, c);
    repeat (12 * n - (mid ? 6 : 3)) @(posedge ref_clk_i);
    if (mid) rd(ctl, c | 8'h20);
    wr(ctl, stp);
  endtask
  // Completed reads are compared with the oldest note.
  always @(posedge ref_clk_i) begin
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0)
      cmp(avs_readdata_o, exp_q.pop_front());
  end
  // Main sequence.
  initial begin
    {rst_n_i, avs_read_i, avs_write_i, ov_ack, rq_ack, start} = 6'h00;
    {lvl, avs_address_i, avs_writedata_i, avs_byteenable_i} = {1'b1, 46'h0};
    {npulse, seed, bad_count, n_compared} = {4'h1, 32'h826C, 64'h0};
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    foreach (regs[k]) rd(regs[k], 8'h00);
    wr(10'h3FC, 8'h5A);
    rd(10'h3FC, 8'h00);
    bus(1'b0, `ADDR_RELOAD_LOW, 32'h77, 4'h0);
    rd(`ADDR_RELOAD_LOW, 8'h00);
    wcnt(16'h00FA);
    run(8'h90, 8'h80, 10, 1'b0);
    rcnt(16'h0104);
    repeat (30) @(posedge ref_clk_i);
    rcnt(16'h0104);
    lvl <= 1'b0;
    wcnt(16'h0000);
    run(8'h90, 8'h80, 10, 1'b0);
    rcnt(16'h0000);
    run(8'h10, 8'h00, 10, 1'b0);
    rcnt(16'h000A);
    lvl <= 1'b1;
    wr(`ADDR_RELOAD_LOW, 8'h34);
    wr(`ADDR_RELOAD_HIGH, 8'h12);
    wr(`ADDR_INTERRUPT_ENABLE, 8'h82);
    wcnt(16'hFFFE);
    run(8'h10, 8'h20, 3, 1'b1);
    rcnt(16'h1235);
    rd(`ADDR_RELOAD_LOW, 8'h34);
    rd(`ADDR_RELOAD_HIGH, 8'h12);
    cmp({31'h0, overflow_irq_o}, 32'h1);
    @(posedge ref_clk_i) ov_ack <= 1'b1;
    @(posedge ref_clk_i) ov_ack <= 1'b0;
    rd(ctl, 8'h00);
    cmp({31'h0, overflow_irq_o}, 32'h0);
    npulse <= 4'(xs() % 7 + 1);
    wcnt(16'h0000);
    wr(ctl, 8'h50);
    @(posedge ref_clk_i) start <= 1'b1;
    @(posedge ref_clk_i) start <= 1'b0;
    for (i = 0; done !== 1'b1 && i < 1000; i++) @(negedge ref_clk_i);
    if (i >= 1000) begin
      cmp(32'h0, 32'h1);
      summarize();
    end
    wr(ctl, 8'h40);
    rcnt({12'h000, npulse});
    wr(ctl, 8'h04);
    wr(`ADDR_INTERRUPT_ENABLE, 8'h81);
    @(posedge ref_clk_i) lvl <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rd(ctl, 8'h0C);
    cmp({31'h0, request_a_irq_o}, 32'h1);
    @(posedge ref_clk_i) rq_ack <= 1'b1;
    @(posedge ref_clk_i) rq_ack <= 1'b0;
    rd(ctl, 8'h04);
    summarize();
  end
endmodule // test_auto_reload_timer_counter
